// File: rtl/prescaler_and_status_select.v
// Feedback prescaler configuration, feedback divider and status pin routing.
`timescale 1ns/1ps
`include "fb_presc_map.vh"

// What this block does
// R1: Fixed-divide codes divide by a constant 1, 2 or 3 with no modulus switching.
// R2: Code 010 divides by 2 and 3 when the swallow count is nonzero, else only by 2.
// R3: Code 011 divides by 4 and 5 when the swallow count is nonzero, else only by 4.
// R4: Code 100 divides by 8 and 9 when the swallow count is nonzero, else only by 8.
// R5: Code 101 divides by 16 and 17 when the swallow count is nonzero, else only by 16.
// R6: Code 110 divides by 32 and 33 (32 alone when swallow is zero) and is the reset default.
// R7: Software keeps the guard bit clear when reprogramming the status select; otherwise it is kept.
// R8: Status select code 0 drives ground and code 1 the delayed feedback divider output.
// R9: Codes 2 to 5 drive the delayed reference divider, swallow counter, prescaler and detector up pulse.
// R10: Main counter bypass divides by one and is honoured only in fixed-divide modes.
// R11: Dual modulus uses the larger modulus while swallow counts down, then the smaller one.
module prescaler_and_status_select (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Register port
   input wire [`ADDR_W-1:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata_ff,
   // Signals for the status pin
   input wire ref_div_in,
   input wire pd_up_in,
   // Outputs
   output reg status_pin_ff,
   output wire fb_div_out
);
   // ==========================================================
   // Registers
   reg [2:0] presc_mode_ff;
   reg bypass_ff;
   reg [5:0] status_sel_ff;
   reg guard_ff;
   reg [`CNT_W-1:0] swallow_ld_ff;
   reg [`MAIN_W-1:0] main_ld_ff;

   function is_fixed;
      input [2:0] m;
      begin
         is_fixed = (m == `P_FD1) || (m == `P_FD2) || (m == `P_FD3);
      end
   endfunction

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         presc_mode_ff <= `PRESC_RST; // R6
         bypass_ff <= 1'b0;
         status_sel_ff <= `SEL_RST; // R8
         guard_ff <= 1'b0;
         swallow_ld_ff <= `SWALLOW_RST;
         main_ld_ff <= `MAIN_RST;
      end else if (wr) begin
         case (addr)
            `OFS_PRESC_CTRL: begin
               presc_mode_ff <= wdata[`PRESC_MSB:`PRESC_LSB];
               bypass_ff <= wdata[`BYPASS_BIT];
            end
            `OFS_STATUS_SEL: begin
               if (!guard_ff) begin
                  status_sel_ff <= wdata[`SEL_MSB:`SEL_LSB]; // R7
               end
            end
            `OFS_GUARD: guard_ff <= wdata[`GUARD_BIT];
            `OFS_SWALLOW: swallow_ld_ff <= wdata[`CNT_W-1:0];
            `OFS_MAIN_CNT: main_ld_ff <= wdata;
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Prescaler and feedback divider
   reg [`CNT_W-1:0] swallow_ff;
   reg [`MAIN_W-1:0] main_ff;
   reg fb_ff;
   reg [`DELAY_W-1:0] fb_dly_ff;
   reg [`DELAY_W-1:0] ref_dly_ff;
   reg [2:0] up_sync_ff;
   reg swallow_out_ff;
   wire presc_tick;
   wire fixed = is_fixed(presc_mode_ff);
   wire bypass_eff = bypass_ff && fixed; // R10
   wire use_large = !fixed && (swallow_ff != {`CNT_W{1'b0}}); // R11

   presc_core u_core (
      .clk(clk),
      .rst(rst),
      .mode(presc_mode_ff),
      .use_large(use_large),
      .presc_tick_ff(presc_tick)
   );

   wire main_end = bypass_eff || (main_ff <= `ONE8); // R10

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         swallow_ff <= `SWALLOW_RST;
         main_ff <= `MAIN_RST;
         fb_ff <= 1'b0;
         swallow_out_ff <= 1'b0;
      end else if (presc_tick) begin
         if (main_end) begin
            swallow_ff <= swallow_ld_ff; // R11
            main_ff <= main_ld_ff;
            fb_ff <= ~fb_ff;
         end else begin
            main_ff <= main_ff - `ONE8;
            if (swallow_ff != {`CNT_W{1'b0}}) begin
               swallow_ff <= swallow_ff - `ONE6; // R11
            end
         end
         swallow_out_ff <= (swallow_ff == `ONE6);
      end else begin
         swallow_out_ff <= 1'b0;
      end
   end

   // ==========================================================
   // Delay stages and pin input synchroniser
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         fb_dly_ff <= {`DELAY_W{1'b0}};
         ref_dly_ff <= {`DELAY_W{1'b0}};
         up_sync_ff <= 3'h0;
      end else begin
         fb_dly_ff <= {fb_dly_ff[`DELAY_W-2:0], fb_ff};
         ref_dly_ff <= {ref_dly_ff[`DELAY_W-2:0], ref_div_in};
         up_sync_ff <= {up_sync_ff[1:0], pd_up_in};
      end
   end

   reg up_level_ff;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         up_level_ff <= 1'b0;
      end else if (up_sync_ff[1] == up_sync_ff[2]) begin
         up_level_ff <= up_sync_ff[2];
      end
   end

   assign fb_div_out = fb_dly_ff[`DELAY_W-1];

   // ==========================================================
   // Status pin routing
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         status_pin_ff <= 1'b0;
      end else begin
         case (status_sel_ff)
            `S_GND: status_pin_ff <= 1'b0; // R8
            `S_FB_DIV: status_pin_ff <= fb_dly_ff[`DELAY_W-1]; // R8
            `S_REF_DIV: status_pin_ff <= ref_dly_ff[`DELAY_W-1]; // R9
            `S_SWALLOW: status_pin_ff <= swallow_out_ff; // R9
            `S_PRESC: status_pin_ff <= presc_tick; // R9
            `S_PD_UP: status_pin_ff <= up_level_ff; // R9
            default: status_pin_ff <= 1'b0;
         endcase
      end
   end

   // ==========================================================
   // Read port
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= 8'h00;
      end else if (rd) begin
         case (addr)
            `OFS_PRESC_CTRL: rdata_ff <= {4'h0, bypass_ff, presc_mode_ff};
            `OFS_STATUS_SEL: rdata_ff <= {status_sel_ff, 2'h0};
            `OFS_GUARD: rdata_ff <= {guard_ff, 7'h00};
            `OFS_SWALLOW: rdata_ff <= {2'h0, swallow_ld_ff};
            `OFS_MAIN_CNT: rdata_ff <= main_ld_ff;
            `OFS_BLOCK_STAT: rdata_ff <= {1'b0, fb_ff, swallow_ff};
            default: rdata_ff <= 8'h00;
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end
endmodule

// File: common/fb_presc_map.vh
// Register offsets, field positions, reset values and encodings for the feedback prescaler block.
`ifndef FB_PRESC_MAP_VH
`define FB_PRESC_MAP_VH
// ==========================================================
// Register offsets
`define ADDR_W 10
`define OFS_PRESC_CTRL 10'h016
`define OFS_STATUS_SEL 10'h017
`define OFS_GUARD 10'h01D
`define OFS_SWALLOW 10'h020
`define OFS_MAIN_CNT 10'h021
`define OFS_BLOCK_STAT 10'h022
// ==========================================================
// Fields
`define PRESC_LSB 0
`define PRESC_MSB 2
`define BYPASS_BIT 3
`define SEL_LSB 2
`define SEL_MSB 7
`define GUARD_BIT 7
// ==========================================================
// Reset values
`define PRESC_RST 3'h6
`define SEL_RST 6'h00
`define SWALLOW_RST 6'h00
`define MAIN_RST 8'h03
// ==========================================================
// Prescaler codes
`define P_FD1 3'h0
`define P_FD2 3'h1
`define P_DM2 3'h2
`define P_DM4 3'h3
`define P_DM8 3'h4
`define P_DM16 3'h5
`define P_DM32 3'h6
`define P_FD3 3'h7
// ==========================================================
// Status select codes
`define S_GND 6'h00
`define S_FB_DIV 6'h01
`define S_REF_DIV 6'h02
`define S_SWALLOW 6'h03
`define S_PRESC 6'h04
`define S_PD_UP 6'h05
// ==========================================================
// Widths and constants
`define CNT_W 6
`define MAIN_W 8
`define DELAY_W 4
`define ONE6 6'h01
`define ONE8 8'h01
// ==========================================================
// Prescaler moduli
`define DIV_1 6'h01
`define DIV_2 6'h02
`define DIV_3 6'h03
`define DIV_4 6'h04
`define DIV_8 6'h08
`define DIV_16 6'h10
`define DIV_32 6'h20
`endif

// File: rtl/presc_core.v
// Dual-modulus feedback prescaler core running on the VCO clock.
`timescale 1ns/1ps
`include "fb_presc_map.vh"

module presc_core (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Configuration
   input wire [2:0] mode,
   input wire use_large,
   // Output
   output reg presc_tick_ff
);
   // ==========================================================
   // Modulus decode
   reg [`CNT_W-1:0] cnt_ff;
   reg [`CNT_W-1:0] nxt_cnt;
   reg [`CNT_W-1:0] base;
   reg dual;

   always @* begin
      base = `DIV_32;
      dual = 1'b1;
      case (mode)
         `P_FD1: begin
            base = `DIV_1; // R1
            dual = 1'b0;
         end
         `P_FD2: begin
            base = `DIV_2; // R1
            dual = 1'b0;
         end
         `P_FD3: begin
            base = `DIV_3; // R1
            dual = 1'b0;
         end
         `P_DM2: base = `DIV_2; // R2
         `P_DM4: base = `DIV_4; // R3
         `P_DM8: base = `DIV_8; // R4
         `P_DM16: base = `DIV_16; // R5
         `P_DM32: base = `DIV_32; // R6
         default: base = `DIV_32;
      endcase
   end

   // Terminal count is base-1, plus one more when the larger modulus is in use.
   wire [`CNT_W-1:0] term = (dual && use_large) ? base : base - `ONE6; // R11

   always @* begin
      nxt_cnt = (cnt_ff >= term) ? {`CNT_W{1'b0}} : cnt_ff + `ONE6;
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= {`CNT_W{1'b0}};
         presc_tick_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         presc_tick_ff <= (cnt_ff >= term);
      end
   end
endmodule

// File: tb/prescaler_and_status_select_assertions.sv
// Checker for the register port and status pin routing of the prescaler block.
`timescale 1ns/1ps
module prescaler_and_status_select_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [9:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata_ff,
   // Status pin sources and outputs
   input wire logic ref_div_in,
   input wire logic pd_up_in,
   input wire logic status_pin_ff,
   input wire logic fb_div_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // Shadow copies of the prescaler mode, status select and guard registers
   logic [5:0] sel_ff;
   logic guard_ff;
   logic [2:0] presc_ff;
   wire mapped = addr == 10'h016 || addr == 10'h017 || addr == 10'h01D || (addr >= 10'h020 && addr <= 10'h022);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sel_ff <= 6'h00;
         guard_ff <= 1'b0;
         presc_ff <= 3'h6;
      end else if (wr) begin
         if (addr == 10'h01D) guard_ff <= wdata[7];
         if (addr == 10'h017 && !guard_ff) sel_ff <= wdata[7:2];
         if (addr == 10'h016) presc_ff <= wdata[2:0];
      end
   end
   // ==========================================================
   // Properties
   property p_rd_idle; !$past(rd) |-> rdata_ff == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");
   property p_unmapped; rd && !mapped |=> rdata_ff == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_presc_rd; rd && addr == 10'h016 |=> rdata_ff[2:0] == $past(presc_ff); endproperty
   a_presc_rd: assert property (p_presc_rd) else $error("prescaler mode readback wrong");
   property p_sel_rd; rd && addr == 10'h017 |=> rdata_ff[7:2] == $past(sel_ff); endproperty
   a_sel_rd: assert property (p_sel_rd) else $error("status select readback wrong");
   property p_gnd; $past(sel_ff) == 6'h00 |-> !status_pin_ff; endproperty
   a_gnd: assert property (p_gnd) else $error("status pin not ground");
   property p_fb; $past(sel_ff) == 6'h01 |-> status_pin_ff == $past(fb_div_out); endproperty
   a_fb: assert property (p_fb) else $error("status pin not feedback output");
   property p_ref;
      sel_ff == 6'h02 && $rose(ref_div_in) |-> ##[3:6] (status_pin_ff || sel_ff != 6'h02);
   endproperty
   a_ref: assert property (p_ref) else $error("status pin missed reference edge");
   property p_pd;
      sel_ff == 6'h05 && $rose(pd_up_in) |-> ##[2:6] (status_pin_ff || sel_ff != 6'h05);
   endproperty
   a_pd: assert property (p_pd) else $error("status pin missed up pulse");
endmodule
bind prescaler_and_status_select prescaler_and_status_select_checker u_chk (.clk(clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .ref_div_in(ref_div_in), .pd_up_in(pd_up_in),
   .status_pin_ff(status_pin_ff), .fb_div_out(fb_div_out));

// File: tb/ref_src_model.sv
// Model of the reference divider and phase detector feeding the status pin.
`timescale 1ns/1ps
module ref_src_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Reference side outputs
   output logic ref_div,
   output logic pd_up
);
   logic [4:0] cnt_ff;
   always @(posedge clk or posedge rst) begin
      if (rst) cnt_ff <= 5'h00;
      else cnt_ff <= (cnt_ff == 5'h13) ? 5'h00 : cnt_ff + 5'h01;
   end
   assign ref_div = cnt_ff[3];
   assign pd_up = cnt_ff > 5'h0D;
endmodule

// File: tb/prescaler_and_status_select_tb.sv
// Self-checking bench for the feedback prescaler and status pin select block.
`timescale 1ns/1ps
module prescaler_and_status_select_tb;
   logic clk = 0, rst = 1, wr = 0, rd = 0, byp;
   logic [9:0] addr = 0;
   logic [7:0] wdata = 0;
   logic [2:0] c;
   wire [7:0] rdata_ff;
   wire status_pin_ff, fb_div_out, ref_div_in, pd_up_in;
   integer n_errors = 0, checks = 0, seed = 20564, i, a, b, cyc;
   prescaler_and_status_select DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_ff(rdata_ff), .ref_div_in(ref_div_in), .pd_up_in(pd_up_in), .status_pin_ff(status_pin_ff),
      .fb_div_out(fb_div_out));
   ref_src_model u_src (.clk(clk), .rst(rst), .ref_div(ref_div_in), .pd_up(pd_up_in));
   initial begin
      forever #5 clk = ~clk;
   end
   // ==========================================================
   // Tasks and expectations
   task wrap_up;
      if (n_errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task wr_reg(input logic [9:0] ad, input logic [7:0] d);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_chk(input logic [9:0] ad, input logic [7:0] exp);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 cmp("rdata", {24'h0, exp}, {24'h0, rdata_ff});
   endtask
   // Counts cycles until the feedback output next toggles.
   task half;
      logic v;
      v = fb_div_out;
      cyc = 0;
      while (fb_div_out === v && cyc < 400) begin
         @(posedge clk);
         #1 cyc++;
      end
   endtask
   function integer exp_n(input logic [2:0] cd, input integer bb, input integer aa, input logic bp);
      integer p;
      case (cd)
         3'h0: p = 1;
         3'h1, 3'h2: p = 2;
         3'h7: p = 3;
         3'h3: p = 4;
         3'h4: p = 8;
         3'h5: p = 16;
         default: p = 32;
      endcase
      if (cd == 3'h0 || cd == 3'h1 || cd == 3'h7) return bp ? p : p * bb;
      return p * bb + aa;
   endfunction
   // Counts rising edges of the status pin over a window of 60 cycles.
   task rise_cnt;
      logic p;
      #1 p = status_pin_ff;
      cyc = 0;
      repeat (60) begin
         @(posedge clk);
         #1 if (status_pin_ff === 1'b1 && p === 1'b0) cyc++;
         p = status_pin_ff;
      end
   endtask
   // Rising edges per 60 cycles with fixed divide-by-2, main load 3 and a reference source period of 20.
   function integer exp_rise(input integer code);
      case (code)
         1: exp_rise = 60 / (2 * exp_n(3'h1, 3, 1, 1'b0));
         2, 5: exp_rise = 60 / 20;
         3: exp_rise = 60 / exp_n(3'h1, 3, 1, 1'b0);
         4: exp_rise = 60 / 2;
         default: exp_rise = 0;
      endcase
   endfunction
   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk(10'h016, 8'h06);
      rd_chk(10'h017, 8'h00);
      rd_chk(10'h3FF, 8'h00);
      wr_reg(10'h01D, 8'h80);
      wr_reg(10'h017, 8'h08);
      rd_chk(10'h017, 8'h00);
      wr_reg(10'h01D, 8'h00);
      wr_reg(10'h017, 8'h04);
      for (i = 0; i < 12; i++) begin
         c = (i < 8) ? i[2:0] : 3'($random(seed));
         b = 2 + {$random(seed)} % 4;
         a = (i == 2) ? 0 : {$random(seed)} % b;
         byp = (i == 1 || i == 6) ? 1'b1 : 1'($random(seed));
         wr_reg(10'h016, {4'h0, byp, c});
         wr_reg(10'h020, a[7:0]);
         wr_reg(10'h021, b[7:0]);
         repeat (4) half;
         cmp("fb_half_period", exp_n(c, b, a, byp), cyc);
      end
      wr_reg(10'h016, 8'h01);
      wr_reg(10'h020, 8'h01);
      wr_reg(10'h021, 8'h03);
      repeat (3) half;
      for (i = 1; i < 6; i++) begin
         wr_reg(10'h017, {i[5:0], 2'h0});
         repeat (8) @(posedge clk);
         rise_cnt;
         cmp("status_rises", exp_rise(i), cyc);
      end
      rd_chk(10'h017, 8'h14);
      wrap_up;
   end
   initial begin
      #200000;
      n_errors++;
      wrap_up;
   end
endmodule
